// *** core/rper_cfg_if.sv ***
// interface: configuration access strobes shared between port modules
`timescale 1ns/10ps
interface rper_cfg_if;
   logic wrEn;
   logic [31:0] wrData;
   logic [3:0] byteEn;
   modport src (output wrEn, output wrData, output byteEn);
   modport dst (input wrEn, input wrData, input byteEn);
endinterface

// *** core/rper_pkg.sv ***
// package: offsets, field positions and reset values of the event routing regs
package rper_pkg;
   // ------------------------------------------------------------------
   // register offsets (configuration space byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] MISC_PORT_CONFIG_OFS = 8'hD8;
   localparam logic [7:0] SMI_SCI_FLAGS_OFS = 8'hDC;
   localparam logic [7:0] FUNCTION_OFF_CONTROL_OFS = 8'hFC;
   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] MISC_PORT_CONFIG_RST = 32'h0011_0000;
   localparam logic [31:0] SMI_SCI_FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] FUNCTION_OFF_CONTROL_RST = 32'h0000_0000;
   // ------------------------------------------------------------------
   // writable bit masks; reserved bits stay zero
   // ------------------------------------------------------------------
   localparam logic [31:0] MISC_PORT_CONFIG_WMASK = 32'hF01F_8F03;
   localparam logic [31:0] SMI_SCI_FLAGS_W1C = 32'hC000_0013;
   localparam logic [31:0] FUNCTION_OFF_CONTROL_WMASK = 32'h0000_0005;
   // ------------------------------------------------------------------
   // field positions of misc_port_config
   // ------------------------------------------------------------------
   localparam int PM_SCI_ENABLE_POS = 31;
   localparam int HOTPLUG_SCI_ENABLE_POS = 30;
   localparam int LINK_TLP_BLOCK_POS = 29;
   localparam int ADDR_XOR_ENABLE_POS = 28;
   localparam int OWN_CLOCK_L0S_LSB = 18;
   localparam int COMMON_CLOCK_L0S_LSB = 15;
   localparam int ADDR_XOR_BITS_LSB = 8;
   localparam int HOTPLUG_SMI_ENABLE_POS = 1;
   localparam int PM_SMI_ENABLE_POS = 0;
   // ------------------------------------------------------------------
   // field positions of smi_sci_flags and function_off_control
   // ------------------------------------------------------------------
   localparam int PM_SCI_FLAG_POS = 31;
   localparam int HOTPLUG_SCI_FLAG_POS = 30;
   localparam int LINK_ACTIVE_CHANGE_SMI_FLAG_POS = 4;
   localparam int PRESENCE_CHANGE_SMI_FLAG_POS = 1;
   localparam int PM_SMI_FLAG_POS = 0;
   localparam int CLOCK_IDLE_STOP_DISABLE_POS = 2;
   localparam int FUNCTION_DISABLE_POS = 0;
endpackage

// *** core/rper_regs.sv ***
// module: root port event routing registers and their effects
`timescale 1ns/10ps
// Notes on behaviour
// - pm event raises sci when enabled
// - hotplug event raises sci when enabled
// - block bit stops accepting tlps
// - loopback xor of address top nibble
// - own clock l0s latency when ccc clear
// - common clock l0s latency when ccc set
// - slot status rise raises smi when hotplug smi enabled
// - root pme rise raises smi when pm smi enabled
// - pm sci flag sets, write one clears
// - hotplug sci flag sets, write one clears
// - link active rise sets flag, smi
// - presence rise sets flag, smi
// - root pme rise sets pm smi flag
// - clock idle stop disable bit
// - function disable bit
// - reset values of all three registers
module rper_regs (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   input wire logic pmEvent,
   input wire logic hotplugEvent,
   input wire logic slotLinkActiveChanged,
   input wire logic slotPresenceChanged,
   input wire logic rootPmeStatus,
   input wire logic commonClockConfig,
   input wire logic loopbackActive,
   input wire logic rxAddrValid,
   input wire logic [31:0] rxAddr,
   output logic [31:0] rxAddrOut,
   output logic rxAddrOutValid,
   output logic tlpAccept,
   output logic [2:0] l0sExitLatency,
   output logic sciOut,
   output logic smiOut,
   output logic clockGateEnable,
   output logic functionEnable
);
   // ------------------------------------------------------------------
   // elaboration checks on the package constants
   // ------------------------------------------------------------------
   // a reset value outside the storable bits could never be cleared by a write
   if ((rper_pkg::MISC_PORT_CONFIG_RST &
        ~rper_pkg::MISC_PORT_CONFIG_WMASK) != '0) begin : gMpcRst
      $error("misc_port_config reset value has unstorable bits");
   end
   if ((rper_pkg::SMI_SCI_FLAGS_RST &
        ~rper_pkg::SMI_SCI_FLAGS_W1C) != '0) begin : gFlagRst
      $error("smi_sci_flags reset value has unstorable bits");
   end
   if ((rper_pkg::FUNCTION_OFF_CONTROL_RST &
        ~rper_pkg::FUNCTION_OFF_CONTROL_WMASK) != '0) begin : gFdRst
      $error("function_off_control reset value has unstorable bits");
   end
   // the decode compares word addresses, so offsets must be word aligned
   if (rper_pkg::MISC_PORT_CONFIG_OFS[1:0] != 2'h0 ||
       rper_pkg::SMI_SCI_FLAGS_OFS[1:0] != 2'h0 ||
       rper_pkg::FUNCTION_OFF_CONTROL_OFS[1:0] != 2'h0) begin : gOfsAlign
      $error("register offsets must be word aligned");
   end
   // two registers on one word would both take the same write
   if (rper_pkg::MISC_PORT_CONFIG_OFS == rper_pkg::SMI_SCI_FLAGS_OFS ||
       rper_pkg::MISC_PORT_CONFIG_OFS == rper_pkg::FUNCTION_OFF_CONTROL_OFS ||
       rper_pkg::SMI_SCI_FLAGS_OFS ==
       rper_pkg::FUNCTION_OFF_CONTROL_OFS) begin : gOfsUniq
      $error("register offsets must differ");
   end
   // multi-bit fields must sit wholly inside the 32-bit word
   if (rper_pkg::OWN_CLOCK_L0S_LSB + 3 > 32 ||
       rper_pkg::COMMON_CLOCK_L0S_LSB + 3 > 32 ||
       rper_pkg::ADDR_XOR_BITS_LSB + 4 > 32) begin : gFieldFit
      $error("a register field runs past bit 31");
   end
   // every flag that hardware sets must also be clearable by software
   if (!rper_pkg::SMI_SCI_FLAGS_W1C[rper_pkg::PM_SCI_FLAG_POS] ||
       !rper_pkg::SMI_SCI_FLAGS_W1C[rper_pkg::HOTPLUG_SCI_FLAG_POS] ||
       !rper_pkg::SMI_SCI_FLAGS_W1C[rper_pkg::LINK_ACTIVE_CHANGE_SMI_FLAG_POS] ||
       !rper_pkg::SMI_SCI_FLAGS_W1C[rper_pkg::PRESENCE_CHANGE_SMI_FLAG_POS] ||
       !rper_pkg::SMI_SCI_FLAGS_W1C[rper_pkg::PM_SMI_FLAG_POS]) begin : gFlg
      $error("a flag position lies outside the clearable mask");
   end
   // every enable bit that routes an event must be storable
   if (!rper_pkg::MISC_PORT_CONFIG_WMASK[rper_pkg::PM_SCI_ENABLE_POS] ||
       !rper_pkg::MISC_PORT_CONFIG_WMASK[rper_pkg::HOTPLUG_SCI_ENABLE_POS] ||
       !rper_pkg::MISC_PORT_CONFIG_WMASK[rper_pkg::PM_SMI_ENABLE_POS] ||
       !rper_pkg::MISC_PORT_CONFIG_WMASK[
          rper_pkg::HOTPLUG_SMI_ENABLE_POS]) begin : gEnMask
      $error("an enable position lies outside the writable mask");
   end

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [31:0] miscPortConfig_reg;
   logic [31:0] smiSciFlags_reg;
   logic [31:0] functionOffControl_reg;
   logic [31:0] mpcMerged;
   logic [31:0] fdMerged;
   logic [31:0] flagOnes;
   logic [31:0] flagSet;
   logic [31:0] flagClr;
   logic [31:0] smiSciFlags_next;
   logic [2:0] rises;
   logic wrMpc;
   logic wrFlags;
   logic wrFd;
   logic pmSciEn;
   logic hpSciEn;
   logic pmSmiEn;
   logic hpSmiEn;
   logic linkTlpBlock;
   logic addrXorEnable;
   logic [3:0] addrXorBits;
   logic [2:0] ownClockL0s;
   logic [2:0] commonClockL0s;

   rper_cfg_if cfg ();

   // configuration strobes carried to the merge units
   assign cfg.wrEn = cfgWr;
   assign cfg.wrData = cfgWrData;
   assign cfg.byteEn = cfgByteEn;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction

   assign wrMpc = cfgWr && hit(cfgAddr, rper_pkg::MISC_PORT_CONFIG_OFS);
   assign wrFlags = cfgWr && hit(cfgAddr, rper_pkg::SMI_SCI_FLAGS_OFS);
   assign wrFd = cfgWr && hit(cfgAddr, rper_pkg::FUNCTION_OFF_CONTROL_OFS);

   // two merge units handle the plain writable regs, a third the flag one
   rper_wr_merge mpcMerge (
      .cfg(cfg),
      .oldVal(miscPortConfig_reg),
      .wmask(rper_pkg::MISC_PORT_CONFIG_WMASK),
      .newVal(mpcMerged),
      .oneBits()
   );

   rper_wr_merge fdMerge (
      .cfg(cfg),
      .oldVal(functionOffControl_reg),
      .wmask(rper_pkg::FUNCTION_OFF_CONTROL_WMASK),
      .newVal(fdMerged),
      .oneBits()
   );

   rper_wr_merge flagMerge (
      .cfg(cfg),
      .oldVal(smiSciFlags_reg),
      .wmask(rper_pkg::SMI_SCI_FLAGS_W1C),
      .newVal(),
      .oneBits(flagOnes)
   );

   // ------------------------------------------------------------------
   // status edge detection
   // ------------------------------------------------------------------
   rper_rise_det #(.WIDTH(3)) riseDet (
      .mclk(mclk),
      .rst_n(rst_n),
      .level({slotLinkActiveChanged, slotPresenceChanged, rootPmeStatus}),
      .rise(rises)
   );

   assign pmSciEn = miscPortConfig_reg[rper_pkg::PM_SCI_ENABLE_POS];
   assign hpSciEn = miscPortConfig_reg[rper_pkg::HOTPLUG_SCI_ENABLE_POS];
   assign pmSmiEn = miscPortConfig_reg[rper_pkg::PM_SMI_ENABLE_POS];
   assign hpSmiEn = miscPortConfig_reg[rper_pkg::HOTPLUG_SMI_ENABLE_POS];

   // named fields of misc_port_config, read by the link control outputs
   assign linkTlpBlock = miscPortConfig_reg[rper_pkg::LINK_TLP_BLOCK_POS];
   assign addrXorEnable = miscPortConfig_reg[rper_pkg::ADDR_XOR_ENABLE_POS];
   assign addrXorBits = miscPortConfig_reg[rper_pkg::ADDR_XOR_BITS_LSB +: 4];
   assign ownClockL0s = miscPortConfig_reg[rper_pkg::OWN_CLOCK_L0S_LSB +: 3];
   assign commonClockL0s =
      miscPortConfig_reg[rper_pkg::COMMON_CLOCK_L0S_LSB +: 3];

   // ------------------------------------------------------------------
   // misc_port_config register
   // ------------------------------------------------------------------
   // reserved bits are masked out of the merge so they stay zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         miscPortConfig_reg <= rper_pkg::MISC_PORT_CONFIG_RST;
      end else if (wrMpc) begin
         miscPortConfig_reg <= mpcMerged;
      end
   end

   // ------------------------------------------------------------------
   // function_off_control register
   // ------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         functionOffControl_reg <= rper_pkg::FUNCTION_OFF_CONTROL_RST;
      end else if (wrFd) begin
         functionOffControl_reg <= fdMerged;
      end
   end

   // ------------------------------------------------------------------
   // smi_sci_flags register, write one to clear
   // ------------------------------------------------------------------
   // set sources; an event in the clear cycle still lands
   always_comb begin
      flagSet = '0;
      flagSet[rper_pkg::PM_SCI_FLAG_POS] = pmEvent && pmSciEn;
      flagSet[rper_pkg::HOTPLUG_SCI_FLAG_POS] =
         hotplugEvent && hpSciEn;
      flagSet[rper_pkg::LINK_ACTIVE_CHANGE_SMI_FLAG_POS] =
         rises[2] && hpSmiEn;
      flagSet[rper_pkg::PRESENCE_CHANGE_SMI_FLAG_POS] =
         rises[1] && hpSmiEn;
      flagSet[rper_pkg::PM_SMI_FLAG_POS] = rises[0] && pmSmiEn;
      flagClr = wrFlags ? flagOnes : '0;
      // set wins over clear
      smiSciFlags_next = ((smiSciFlags_reg & ~flagClr) | flagSet) &
                         rper_pkg::SMI_SCI_FLAGS_W1C;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         smiSciFlags_reg <= rper_pkg::SMI_SCI_FLAGS_RST;
      end else begin
         smiSciFlags_reg <= smiSciFlags_next;
      end
   end

   // ------------------------------------------------------------------
   // interrupt routing outputs
   // ------------------------------------------------------------------
   // sci follows the sticky sci flags of the next cycle, so it stays up
   // until software clears them
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sciOut <= 1'b0;
      end else begin
         sciOut <= smiSciFlags_next[rper_pkg::PM_SCI_FLAG_POS] ||
                   smiSciFlags_next[rper_pkg::HOTPLUG_SCI_FLAG_POS];
      end
   end

   // smi asserted while any smi flag stands
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         smiOut <= 1'b0;
      end else begin
         smiOut <=
            smiSciFlags_next[rper_pkg::LINK_ACTIVE_CHANGE_SMI_FLAG_POS] ||
            smiSciFlags_next[rper_pkg::PRESENCE_CHANGE_SMI_FLAG_POS] ||
            smiSciFlags_next[rper_pkg::PM_SMI_FLAG_POS];
      end
   end

   // ------------------------------------------------------------------
   // link control outputs
   // ------------------------------------------------------------------
   // tlpAccept follows the register next state so it changes with it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tlpAccept <= 1'b1;
      end else begin
         tlpAccept <= !(wrMpc ? mpcMerged[rper_pkg::LINK_TLP_BLOCK_POS] :
            linkTlpBlock);
      end
   end

   // latency chosen from the live clocking mode
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         l0sExitLatency <=
            rper_pkg::MISC_PORT_CONFIG_RST[rper_pkg::OWN_CLOCK_L0S_LSB +: 3];
      end else if (commonClockConfig) begin
         l0sExitLatency <= commonClockL0s;
      end else begin
         l0sExitLatency <= ownClockL0s;
      end
   end

   // one cycle pipeline of receive address with loopback xor
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxAddrOut <= 32'h0000_0000;
         rxAddrOutValid <= 1'b0;
      end else begin
         rxAddrOutValid <= rxAddrValid;
         rxAddrOut <= rxAddr;
         if (loopbackActive && addrXorEnable) begin
            rxAddrOut[31:28] <= rxAddr[31:28] ^ addrXorBits;
         end
      end
   end

   // function controls
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clockGateEnable <= 1'b1;
         functionEnable <= 1'b1;
      end else begin
         clockGateEnable <= !functionOffControl_reg[
            rper_pkg::CLOCK_IDLE_STOP_DISABLE_POS];
         functionEnable <=
            !functionOffControl_reg[rper_pkg::FUNCTION_DISABLE_POS];
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   // unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfgRdData <= 32'h0000_0000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgRd;
         if (!cfgRd) begin
            cfgRdData <= 32'h0000_0000;
         end else if (hit(cfgAddr, rper_pkg::MISC_PORT_CONFIG_OFS)) begin
            cfgRdData <= miscPortConfig_reg;
         end else if (hit(cfgAddr, rper_pkg::SMI_SCI_FLAGS_OFS)) begin
            cfgRdData <= smiSciFlags_reg;
         end else if (hit(cfgAddr, rper_pkg::FUNCTION_OFF_CONTROL_OFS)) begin
            cfgRdData <= functionOffControl_reg;
         end else begin
            cfgRdData <= 32'h0000_0000;
         end
      end
   end
endmodule

// *** core/rper_rise_det.sv ***
// module: rising-edge detector for slot and root status inputs
`timescale 1ns/10ps
module rper_rise_det #(
   parameter int WIDTH = 3
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] prev_reg;

   // refused at elaboration: a detector with no lanes watches nothing
   if (WIDTH < 1) begin : gBadWidth
      $error("width must be at least one");
   end

   // remember last level; inputs are synchronous to mclk
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= level;
      end
   end

   // a 0 to 1 transition only, a held level does not retrigger
   assign rise = level & ~prev_reg;
endmodule

// *** core/rper_wr_merge.sv ***
// module: byte-enable merge of a configuration write into a register
`timescale 1ns/10ps
module rper_wr_merge (
   rper_cfg_if.dst cfg,
   input wire logic [31:0] oldVal,
   input wire logic [31:0] wmask,
   output logic [31:0] newVal,
   output logic [31:0] oneBits
);
   logic [31:0] laneMask;

   // expand byte enables to bit lanes; no lane opens without a write
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         laneMask[i*8 +: 8] = {8{cfg.byteEn[i] & cfg.wrEn}};
      end
   end

   // reserved bits keep old value, which is zero after reset
   assign newVal = (oldVal & ~(laneMask & wmask)) |
                   (cfg.wrData & laneMask & wmask);
   // ones written into enabled lanes, for write-one-to-clear
   assign oneBits = cfg.wrData & laneMask & wmask;
endmodule

// *** verification/rper_far_side.sv ***
// partner: slot and root status source plus receive address source
`timescale 1ns/10ps
module rper_far_side (
   input wire logic mclk,
   output logic slotLinkActiveChanged,
   output logic slotPresenceChanged,
   output logic rootPmeStatus,
   output logic rxAddrValid,
   output logic [31:0] rxAddr
);
   logic [2:0] lvl = 3'h0;
   // index 2 link active, 1 presence, 0 root pme
   assign {slotLinkActiveChanged, slotPresenceChanged, rootPmeStatus} = lvl;
   initial begin
      rxAddrValid = 1'b0;
      rxAddr = 32'h0;
   end
   // change bits stay up a while, as sticky status does, then drop
   task automatic raise(input int idx, input int hold);
      @(negedge mclk) lvl[idx] = 1'b1;
      repeat (hold) @(negedge mclk);
      lvl[idx] = 1'b0;
   endtask
   // bus goes to inverted data after use so stale values cannot pass
   task automatic sendAddr(input logic [31:0] a);
      @(negedge mclk);
      rxAddrValid = 1'b1;
      rxAddr = a;
      @(negedge mclk);
      rxAddrValid = 1'b0;
      rxAddr = ~a;
   endtask
endmodule

// *** verification/rper_regs_sva.sv ***
// checker: port-level assertions for the event routing registers
`timescale 1ns/10ps
module rper_regs_sva (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   input wire logic [31:0] cfgRdData,
   input wire logic cfgRdValid,
   input wire logic pmEvent,
   input wire logic hotplugEvent,
   input wire logic slotLinkActiveChanged,
   input wire logic slotPresenceChanged,
   input wire logic rootPmeStatus,
   input wire logic loopbackActive,
   input wire logic rxAddrValid,
   input wire logic [31:0] rxAddr,
   input wire logic [31:0] rxAddrOut,
   input wire logic rxAddrOutValid,
   input wire logic tlpAccept,
   input wire logic [2:0] l0sExitLatency,
   input wire logic sciOut,
   input wire logic smiOut,
   input wire logic clockGateEnable,
   input wire logic functionEnable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ----
   // helpers
   // ----
   logic mapped;
   logic fdGate;
   logic fdFunc;
   // only these word addresses decode; others must read zero
   assign mapped = cfgAddr[7:2] inside {6'h36, 6'h37, 6'h3F};
   assign fdGate = cfgWrData[2];
   assign fdFunc = cfgWrData[0];
   sequence sFdWrite;
      cfgWr && cfgAddr[7:2] == 6'h3F && cfgByteEn[0];
   endsequence
   sequence sBlockWrite;
      cfgWr && cfgAddr[7:2] == 6'h36 && cfgByteEn[3] && cfgWrData[29];
   endsequence
   // ----
   // assertions
   // ----
   AST_RESET_VALUES: assert property (disable iff (1'b0) !rst_n |=>
      cfgRdData == 32'h0 && !sciOut && !smiOut && tlpAccept &&
      l0sExitLatency == 3'h4 && clockGateEnable && functionEnable)
      else $error("outputs off their reset values");
   AST_UNMAPPED: assert property (cfgRd && !mapped |=>
      cfgRdValid && cfgRdData == 32'h0) else $error("unmapped read nonzero");
   AST_TLP_BLOCK: assert property (sBlockWrite |=> !tlpAccept)
      else $error("packets accepted while blocked");
   AST_ADDR_PASS: assert property (rxAddrValid && !loopbackActive |=>
      rxAddrOutValid && rxAddrOut == $past(rxAddr))
      else $error("address altered outside loopback");
   AST_SCI_CAUSE: assert property ($rose(sciOut) |->
      $past(pmEvent) || $past(hotplugEvent)) else $error("sci without event");
   AST_SCI_HOLD: assert property (sciOut && !cfgWr |=> sciOut)
      else $error("sci dropped without a write");
   AST_SMI_HOLD: assert property (smiOut && !cfgWr |=> smiOut)
      else $error("smi dropped without a write");
   AST_SMI_CAUSE: assert property ($rose(smiOut) |->
      $past(slotLinkActiveChanged) || $past(slotPresenceChanged) ||
      $past(rootPmeStatus)) else $error("smi without status rise");
   AST_FD_WRITE: assert property (sFdWrite |-> ##2
      clockGateEnable == !$past(fdGate, 2) &&
      functionEnable == !$past(fdFunc, 2)) else $error("gating or enable off");
endmodule
bind rper_regs rper_regs_sva chk (.*);

// *** verification/rper_regs_test.sv ***
// testbench: self-checking bench for the event routing registers
`timescale 1ns/10ps
module rper_regs_test;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic cfgWr = 1'b0;
   logic cfgRd = 1'b0;
   logic [7:0] cfgAddr = 8'h00;
   logic [3:0] cfgByteEn = 4'h0;
   logic [31:0] cfgWrData = 32'h0, cfgRdData, rxAddr, rxAddrOut;
   logic cfgRdValid, rxAddrValid, rxAddrOutValid, tlpAccept, sciOut, smiOut;
   logic pmEvent = 1'b0, hotplugEvent = 1'b0, commonClockConfig = 1'b0;
   logic loopbackActive = 1'b0;
   logic slotLinkActiveChanged, slotPresenceChanged, rootPmeStatus;
   logic [2:0] l0sExitLatency;
   logic clockGateEnable, functionEnable;
   int errCount = 0, checked = 0, cycles = 0;
   rper_regs dut (.*);
   rper_far_side far (.*);
   always #2.5 mclk = ~mclk;
   // ----
   // shared tasks
   // ----
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errCount++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic cfgWrite(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      cfgWr = 1'b1;
      cfgAddr = a;
      cfgWrData = d;
      cfgByteEn = 4'hF;
      @(negedge mclk);
      cfgWr = 1'b0;
   endtask
   // read data stands one cycle only, so it is taken at the next negedge
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      @(negedge mclk);
      cfgRd = 1'b1;
      cfgAddr = a;
      @(negedge mclk);
      cfgRd = 1'b0;
      check({31'h0, cfgRdValid}, 32'h1);
      check(cfgRdData, exp);
   endtask
   task automatic evPulse(input logic pm, input logic hp);
      @(negedge mclk);
      pmEvent = pm;
      hotplugEvent = hp;
      @(negedge mclk);
      pmEvent = 1'b0;
      hotplugEvent = 1'b0;
      idle(2);
   endtask
   // ----
   // scenarios
   // ----
   task automatic testReset();
      check({29'h0, l0sExitLatency}, 32'h4);
      check({29'h0, tlpAccept, clockGateEnable, functionEnable}, 32'h7);
      rdChk(8'hD8, 32'h0011_0000);
      rdChk(8'hDC, 32'h0);
      rdChk(8'hFC, 32'h0);
      rdChk(8'hE0, 32'h0);
   endtask
   task automatic testMpc();
      cfgWrite(8'hD8, 32'hFFFF_FFFF);
      rdChk(8'hD8, 32'hF01F_8F03);
      check({31'h0, tlpAccept}, 32'h0);
      cfgWrite(8'hD8, 32'h1010_8A00);
      check({31'h0, tlpAccept}, 32'h1);
      idle(2);
      check({29'h0, l0sExitLatency}, 32'h4);
      commonClockConfig = 1'b1;
      idle(2);
      check({29'h0, l0sExitLatency}, 32'h1);
      commonClockConfig = 1'b0;
      loopbackActive = 1'b1;
      far.sendAddr(32'h1234_5678);
      check({31'h0, rxAddrOutValid}, 32'h1);
      check(rxAddrOut, 32'hB234_5678);
      loopbackActive = 1'b0;
      far.sendAddr(32'h1234_5678);
      check(rxAddrOut, 32'h1234_5678);
   endtask
   task automatic testSci();
      cfgWrite(8'hD8, 32'h0);
      evPulse(1'b1, 1'b1);
      check({30'h0, sciOut, smiOut}, 32'h0);
      rdChk(8'hDC, 32'h0);
      cfgWrite(8'hD8, 32'hC000_0000);
      evPulse(1'b1, 1'b0);
      check({30'h0, sciOut, smiOut}, 32'h2);
      rdChk(8'hDC, 32'h8000_0000);
      cfgWrite(8'hDC, 32'h8000_0000);
      check({31'h0, sciOut}, 32'h0);
      evPulse(1'b0, 1'b1);
      rdChk(8'hDC, 32'h4000_0000);
      cfgWrite(8'hDC, 32'hFFFF_FFFF);
      rdChk(8'hDC, 32'h0);
   endtask
   task automatic testSmi();
      logic [31:0] flag [3] = '{32'h1, 32'h2, 32'h10};
      logic [31:0] en [3] = '{32'h1, 32'h2, 32'h2};
      for (int i = 0; i < 3; i++) begin
         cfgWrite(8'hD8, ~en[i] & 32'h3);
         far.raise(i, 3);
         idle(2);
         rdChk(8'hDC, 32'h0);
         check({31'h0, smiOut}, 32'h0);
         cfgWrite(8'hD8, en[i]);
         far.raise(i, 3);
         idle(2);
         rdChk(8'hDC, flag[i]);
         check({31'h0, smiOut}, 32'h1);
         cfgWrite(8'hDC, flag[i]);
         check({31'h0, smiOut}, 32'h0);
      end
   endtask
   task automatic testFd();
      cfgWrite(8'hFC, 32'hFFFF_FFFF);
      idle(2);
      check({30'h0, clockGateEnable, functionEnable}, 32'h0);
      rdChk(8'hFC, 32'h5);
      cfgWrite(8'hFC, 32'h4);
      idle(2);
      check({30'h0, clockGateEnable, functionEnable}, 32'h1);
   endtask
   // ----
   // run control
   // ----
   task automatic summarize();
      if (errCount == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      testReset();
      testMpc();
      testSci();
      testSmi();
      testFd();
      summarize();
   end
   // the whole run needs about 150 cycles; this ceiling cuts a hang
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errCount++;
         summarize();
      end
   end
endmodule
